//--- dv/rdx_host.sv
// Host flash controller model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module rdx_host (
    input wire logic i_sys_clk, // System clock
    input wire logic [3:0] i_io_out, // Device IO value
    input wire logic [3:0] i_io_oe, // Device IO enable
    output logic o_sck, // Serial clock, low between frames
    output logic o_cs_b, // Chip enable, active low
    output logic [3:0] o_io // Host IO drive
);
    // --------
    // Framing
    // --------
    initial begin
        o_sck = 1'b0;
        o_cs_b = 1'b1;
        o_io = 4'h0;
    end
    task automatic q(int n);
        repeat (2 * n) @(posedge i_sys_clk);
        #1;
    endtask
    // Bits MSB first over n lanes, set mid-phase
    task automatic shift(logic [31:0] d, int w, int n, bit dtr);
        for (int i = w - n; i >= 0; i -= n) begin
            q(1);
            o_io = 4'((d >> i) & ((1 << n) - 1));
            q(1);
            o_sck = ~o_sck;
            if (!dtr) begin
                q(2);
                o_sck = 1'b0;
            end
        end
    endtask
    task automatic frame_end();
        q(2);
        o_cs_b = 1'b1;
        o_io = ~o_io;
        q(4);
    endtask
    task automatic wr(logic [7:0] op, logic [7:0] v, int n);
        o_cs_b = 1'b0;
        shift(op, 8, n, 1'b0);
        shift(v, 8, n, 1'b0);
        frame_end();
    endtask
    task automatic rd(logic [7:0] op, logic [31:0] a, int aw, int n, int cn,
        bit dtr, output int dum, output logic [3:0] first);
        o_cs_b = 1'b0;
        shift(op, 8, cn, 1'b0);
        shift(a, aw, n, dtr);
        dum = 31;
        first = 4'h0;
        // Slow clock leaves room for any dummy count
        for (int k = 0; k < 17; k++) begin
            q(2);
            if (dum == 31 && i_io_oe != 4'h0) begin
                dum = k;
                first = i_io_out & i_io_oe;
            end
            o_io = ~o_io;
            o_sck = 1'b1;
            q(2);
            o_sck = 1'b0;
        end
        frame_end();
    endtask
endmodule
`default_nettype wire

//--- dv/rdx_read_params_sva.sv
// Port assertions for the read-parameter block
`timescale 1ns/1ps
`default_nettype none
module rdx_read_params_sva (
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst_b, // Sync reset, active low
    input wire logic i_sck, // Serial clock pin
    input wire logic i_cs_b, // Chip enable pin
    input wire logic i_qpi_mode, // QPI mode
    input wire logic i_write_in_progress, // Busy flag
    input wire logic i_protection_fail_flag, // Protection error
    input wire logic i_prog_err, // Program error
    input wire logic i_erase_err, // Erase error
    input wire logic [3:0] o_io_oe, // IO drive enable
    input wire logic [7:0] o_ext_params, // Extended register
    input wire logic [7:0] o_rd_params, // Read parameters
    input wire logic [3:0] o_dummy_cnt // Dummy count
);
    // --------
    // Checks
    // --------
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);
    sequence cs_idle_s;
        i_cs_b [*6];
    endsequence
    sequence new_dummy_s;
        $changed(o_dummy_cnt) && o_rd_params[6:3] == 4'h0;
    endsequence
    rsvd_bit_a: assert property (o_ext_params[4] == 1'b1)
        else $error("reserved bit not one");
    status_mirror_a: assert property ($past(i_rst_b) |->
        o_ext_params[3:0] == $past({i_erase_err, i_prog_err,
        i_protection_fail_flag, i_write_in_progress}))
        else $error("status bits do not follow inputs");
    reset_dflt_a: assert property (disable iff (1'b0)
        !i_rst_b |=> o_ext_params[7:4] == 4'hF && o_rd_params == 8'h00
        && o_io_oe == 4'h0 && o_dummy_cnt == 4'h0)
        else $error("reset values wrong");
    dummy_field_a: assert property ($changed(o_dummy_cnt) &&
        o_rd_params[6:3] != 4'h0 |-> o_dummy_cnt == o_rd_params[6:3])
        else $error("dummy count differs from field");
    dummy_qpi_a: assert property (new_dummy_s and i_qpi_mode
        |-> o_dummy_cnt == 4'h6)
        else $error("QPI default dummy not six");
    dummy_spi_a: assert property (new_dummy_s and !i_qpi_mode
        |-> o_dummy_cnt inside {4'h4, 4'h6, 4'h8})
        else $error("SPI default dummy out of set");
    qpi_lanes_a: assert property (i_qpi_mode && o_io_oe != 4'h0
        |-> o_io_oe == 4'hF)
        else $error("narrow drive in QPI");
    oe_idle_a: assert property (cs_idle_s |-> o_io_oe == 4'h0)
        else $error("driving while deselected");
    oe_on_fall_a: assert property ($rose(o_io_oe != 4'h0) |->
        $past(i_sck, 2) == 1'b0 && $past(i_sck, 3) == 1'b0)
        else $error("drive not after falling clock");
    drive_write_a: assert property ($changed(o_ext_params[7:5])
        && $past(i_rst_b, 2) |-> $past(i_cs_b) == 1'b0)
        else $error("drive strength changed outside a frame");
endmodule
bind rdx_read_params rdx_read_params_sva chk_u (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_sck(i_sck),
    .i_cs_b(i_cs_b), .i_qpi_mode(i_qpi_mode),
    .i_write_in_progress(i_write_in_progress),
    .i_protection_fail_flag(i_protection_fail_flag),
    .i_prog_err(i_prog_err), .i_erase_err(i_erase_err),
    .o_io_oe(o_io_oe), .o_ext_params(o_ext_params),
    .o_rd_params(o_rd_params), .o_dummy_cnt(o_dummy_cnt)
);
`default_nettype wire

//--- dv/tb_top.sv
// Random and corner-case bench for the read-parameter block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_sys_clk, i_rst_b, i_qpi_mode, sck, cs_b;
    logic [3:0] stat, host_io, io_out, io_oe, io_pin, dcnt;
    logic [31:0] rd_addr;
    logic [7:0] ext, rdp, rd_byte;
    int fail_count, tests_run, seed;
    // Opcode, addr lanes, data lanes, dtr, default, 4-byte form
    logic [27:0] tbl [11] = '{28'h0B11081, 28'h3B12081, 28'h6B14081,
        28'hBB22041, 28'hEB44061, 28'h0D11181, 28'hBD22141,
        28'hED44161, 28'h7111080, 28'h7211080, 28'h7311080};
    assign io_pin = (io_oe & io_out) | (~io_oe & host_io);
    assign rd_byte = rd_addr[7:0] ^ 8'h5A;
    rdx_read_params dut_u (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_sck(sck),
        .i_cs_b(cs_b), .i_io(io_pin), .o_io_out(io_out), .o_io_oe(io_oe),
        .i_qpi_mode(i_qpi_mode), .i_write_in_progress(stat[0]),
        .i_protection_fail_flag(stat[1]), .i_prog_err(stat[2]),
        .i_erase_err(stat[3]), .i_rd_byte(rd_byte), .o_rd_addr(rd_addr),
        .o_ext_params(ext), .o_rd_params(rdp), .o_dummy_cnt(dcnt)
    );
    rdx_host host_u (
        .i_sys_clk(i_sys_clk), .i_io_out(io_out), .i_io_oe(io_oe),
        .o_sck(sck), .o_cs_b(cs_b), .o_io(host_io)
    );
    // --------
    // Helpers
    // --------
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic do_reset();
        i_rst_b = 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1;
        i_rst_b = 1'b1;
        repeat (4) @(posedge i_sys_clk);
        #1;
        check(ext, {4'hF, stat});
        check(rdp, 8'h00);
    endtask
    function automatic logic [3:0] exp_dum(logic [27:0] t, logic [3:0] fld,
        logic qpi);
        if (fld != 4'h0) begin
            return fld;
        end
        return qpi ? 4'h6 : t[7:4];
    endfunction
    function automatic logic [3:0] exp_first(logic [7:0] b, int dl);
        case (dl)
            1: return {2'b00, b[7], 1'b0};
            2: return {2'b00, b[7:6]};
            default: return b[7:4];
        endcase
    endfunction
    task automatic do_read(logic [27:0] t, logic [3:0] fld);
        logic w4, ok;
        logic [31:0] a;
        int n, dum;
        logic [3:0] first;
        w4 = t[0] & 1'($random(seed));
        a = $random(seed);
        if (!w4) begin
            a[31:24] = 8'h00;
        end
        ok = !i_qpi_mode || (t[19:16] == t[15:12] && t[19:16] != 4'h2);
        n = i_qpi_mode ? 4 : int'(t[19:16]);
        host_u.rd(t[27:20] + 8'(w4), a, w4 ? 32 : 24, n,
            i_qpi_mode ? 4 : 1, t[8], dum, first);
        if (!ok) begin
            check(dum, 31);
        end else begin
            check(dum, exp_dum(t, fld, i_qpi_mode));
            check(dcnt, exp_dum(t, fld, i_qpi_mode));
            check(first, exp_first(a[7:0] ^ 8'h5A,
                i_qpi_mode ? 4 : int'(t[15:12])));
        end
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        logic [7:0] v;
        logic [3:0] fld;
        seed = 1;
        fail_count = 0;
        tests_run = 0;
        i_qpi_mode = 1'b0;
        stat = 4'h0;
        do_reset();
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            stat = 4'($random(seed));
            host_u.wr(8'h83, v, 1);
            check(ext, {v[7:5], 1'b1, stat});
        end
        for (int m = 0; m < 2; m++) begin
            i_qpi_mode = m[0];
            for (int r = 0; r < 4; r++) begin
                fld = r == 0 ? 4'h0 : r == 1 ? 4'h1 : r == 2 ? 4'hF
                    : 4'($random(seed));
                v = 8'($random(seed));
                v[6:3] = fld;
                host_u.wr(r[0] ? 8'hC0 : 8'h63, v, m ? 4 : 1);
                check(rdp, v);
                for (int e = 0; e < 11; e++) begin
                    do_read(tbl[e], fld);
                end
            end
        end
        i_qpi_mode = 1'b0;
        stat = 4'($random(seed));
        do_reset();
        v = 8'($random(seed));
        host_u.wr(8'h85, v, 1);
        check(ext, {4'hF, stat});
        results();
    end
endmodule
`default_nettype wire

//--- include/rdx_pkg.sv
// Constants and types for the read-parameter and extended register block
package rdx_pkg;

    // -------------------------------------------------------------------
    // Command opcodes
    // -------------------------------------------------------------------
    localparam logic [7:0] OP_FAST_RD3 = 8'h0B;
    localparam logic [7:0] OP_FAST_RD4 = 8'h0C;
    localparam logic [7:0] OP_DUAL_OUT3 = 8'h3B;
    localparam logic [7:0] OP_DUAL_OUT4 = 8'h3C;
    localparam logic [7:0] OP_QUAD_OUT3 = 8'h6B;
    localparam logic [7:0] OP_QUAD_OUT4 = 8'h6C;
    localparam logic [7:0] OP_DUAL_IO3 = 8'hBB;
    localparam logic [7:0] OP_DUAL_IO4 = 8'hBC;
    localparam logic [7:0] OP_QUAD_IO3 = 8'hEB;
    localparam logic [7:0] OP_QUAD_IO4 = 8'hEC;
    localparam logic [7:0] OP_SINGLE_DOUBLE_RATE_READ3 = 8'h0D;
    localparam logic [7:0] OP_SINGLE_DOUBLE_RATE_READ4 = 8'h0E;
    localparam logic [7:0] OP_DUAL_IO_DOUBLE_RATE_READ3 = 8'hBD;
    localparam logic [7:0] OP_DUAL_IO_DOUBLE_RATE_READ4 = 8'hBE;
    localparam logic [7:0] OP_QUAD_IO_DOUBLE_RATE_READ3 = 8'hED;
    localparam logic [7:0] OP_QUAD_IO_DOUBLE_RATE_READ4 = 8'hEE;
    localparam logic [7:0] OP_SET_EXT_PARAMS_NONVOLATILE = 8'h85;
    localparam logic [7:0] OP_SET_EXT_PARAMS_VOLATILE = 8'h83;
    localparam logic [7:0] OP_SET_RD_PARAMS_NV = 8'h65;
    localparam logic [7:0] OP_SET_RD_PARAMS_V_A = 8'hC0;
    localparam logic [7:0] OP_SET_RD_PARAMS_V_B = 8'h63;

    // -------------------------------------------------------------------
    // Register layout and reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] RD_PARAMS_RST = 8'h00;
    localparam int RD_DUMMY_LSB = 3;
    localparam logic [3:0] DUMMY_USE_DEFAULT = 4'h0;
    localparam logic [2:0] DRIVE_STRENGTH_RST = 3'h7;
    localparam logic EXT_RSVD_VAL = 1'b1;

    // -------------------------------------------------------------------
    // Default dummy clocks and phase sizes
    // -------------------------------------------------------------------
    localparam logic [3:0] DUM_EIGHT = 4'h8;
    localparam logic [3:0] DUM_SIX = 4'h6;
    localparam logic [3:0] DUM_FOUR = 4'h4;
    localparam logic [5:0] ADDR_BITS3 = 6'h18;
    localparam logic [5:0] ADDR_BITS4 = 6'h20;
    localparam logic [5:0] BYTE_BITS = 6'h08;
    localparam logic [1:0] LSH_ONE = 2'h0;
    localparam logic [1:0] LSH_TWO = 2'h1;
    localparam logic [1:0] LSH_FOUR = 2'h2;

    typedef enum logic [5:0] {
        ST_CMD = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_DUMMY = 6'b000100,
        ST_DATA = 6'b001000,
        ST_WDATA = 6'b010000,
        ST_IGNORE = 6'b100000
    } rdx_state_e;

    typedef struct packed {
        logic ok;
        logic spi_only;
        logic a4;
        logic [1:0] alsh;
        logic [1:0] olsh;
        logic dtr;
        logic [3:0] def_spi;
        logic [3:0] def_qpi;
    } rdx_dec_s;

    typedef struct packed {
        rdx_state_e st;
        logic sck_d;
        logic [5:0] cnt;
        logic [7:0] shift;
        logic [7:0] cmd;
        logic [31:0] addr;
        logic [1:0] alsh;
        logic [1:0] olsh;
        logic dtr;
        logic [3:0] dummy;
        logic [7:0] rp_nv;
        logic [7:0] rp_v;
        logic [2:0] ep_nv;
        logic [2:0] ep_v;
        logic load_pend;
        logic [3:0] io_out;
        logic [3:0] io_oe;
        logic [7:0] ext;
    } rdx_regs_s;

endpackage

//--- logic/rdx_read_params.sv
// Read-parameter, dummy-clock and extended read register logic
// Functional notes
// - Dummy field zero means per-command default
// - Fast and single-line DTR reads: eight SPI, six QPI
// - Dual/quad output reads: eight, SPI only
// - Dual I/O reads: four dummy, SPI only
// - Quad I/O reads: six dummy, both modes
// - Dual I/O DTR read refused in QPI
// - 85h/83h write drive strength bits 7:5
// - Bits 3:0 read-only status, never written
// - Bit 4 reserved, no function
// - Extended default: ones high, zeros low
// - Bit 0 mirrors write-in-progress flag
// - Volatile copies loaded from non-volatile
`timescale 1ns/1ps
`default_nettype none
module rdx_read_params
    import rdx_pkg::*;
#(
    parameter logic [7:0] P_OP_UNIQUE_ID_READ = 8'h71,   // Arbitrary
    parameter logic [7:0] P_OP_PARAM_TABLE_READ = 8'h72, // Arbitrary
    parameter logic [7:0] P_OP_INFO_ROW_READ = 8'h73     // Arbitrary
) (
    input wire logic i_sys_clk,          // 40 MHz system clock
    input wire logic i_rst_b,            // Sync reset, active low
    input wire logic i_sck,              // Serial clock pin
    input wire logic i_cs_b,             // Chip enable pin, active low
    input wire logic [3:0] i_io,         // IO pins, input side
    output logic [3:0] o_io_out,         // IO pins, output value
    output logic [3:0] o_io_oe,          // IO pins, drive enable
    input wire logic i_qpi_mode,         // Device is in QPI mode
    input wire logic i_write_in_progress, // Busy flag
    input wire logic i_protection_fail_flag, // Protection error
    input wire logic i_prog_err,         // Program error
    input wire logic i_erase_err,        // Erase error
    input wire logic [7:0] i_rd_byte,    // Array byte at o_rd_addr
    output logic [31:0] o_rd_addr,       // Next array byte address
    output logic [7:0] o_ext_params,     // Extended read register
    output logic [7:0] o_rd_params,      // Volatile read parameters
    output logic [3:0] o_dummy_cnt       // Dummy clocks of last read
);

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    logic [5:0] pins_s;
    logic s_sck;
    logic s_cs_b;
    logic [3:0] s_io;

    rdx_sync #(.W(6)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_d({i_sck, i_cs_b, i_io}),
        .o_q(pins_s)
    );
    assign s_sck = pins_s[5];
    assign s_cs_b = pins_s[4];
    assign s_io = pins_s[3:0];

    // -------------------------------------------------------------------
    // Command decode
    // -------------------------------------------------------------------
    function automatic rdx_dec_s decode(input logic [7:0] op);
        rdx_dec_s d;
        d = '{ok: 1'b1, spi_only: 1'b0, a4: 1'b0, alsh: LSH_ONE,
              olsh: LSH_ONE, dtr: 1'b0, def_spi: DUM_EIGHT,
              def_qpi: DUM_SIX};
        case (op)
            OP_FAST_RD3, OP_FAST_RD4: begin
                d.a4 = (op == OP_FAST_RD4);
            end
            OP_SINGLE_DOUBLE_RATE_READ3, OP_SINGLE_DOUBLE_RATE_READ4: begin
                d.a4 = (op == OP_SINGLE_DOUBLE_RATE_READ4);
                d.dtr = 1'b1;
            end
            OP_DUAL_OUT3, OP_DUAL_OUT4, OP_QUAD_OUT3, OP_QUAD_OUT4: begin
                d.a4 = (op == OP_DUAL_OUT4) || (op == OP_QUAD_OUT4);
                d.olsh = (op[6]) ? LSH_FOUR : LSH_TWO;
                d.spi_only = 1'b1;
            end
            OP_DUAL_IO3, OP_DUAL_IO4, OP_DUAL_IO_DOUBLE_RATE_READ3,
            OP_DUAL_IO_DOUBLE_RATE_READ4: begin
                d.a4 = (op == OP_DUAL_IO4) ||
                       (op == OP_DUAL_IO_DOUBLE_RATE_READ4);
                d.dtr = (op[3:0] >= OP_DUAL_IO_DOUBLE_RATE_READ3[3:0]);
                d.alsh = LSH_TWO;
                d.olsh = LSH_TWO;
                d.def_spi = DUM_FOUR;
                d.spi_only = 1'b1;
            end
            OP_QUAD_IO3, OP_QUAD_IO4, OP_QUAD_IO_DOUBLE_RATE_READ3,
            OP_QUAD_IO_DOUBLE_RATE_READ4: begin
                d.a4 = (op == OP_QUAD_IO4) ||
                       (op == OP_QUAD_IO_DOUBLE_RATE_READ4);
                d.dtr = (op[3:0] >= OP_QUAD_IO_DOUBLE_RATE_READ3[3:0]);
                d.alsh = LSH_FOUR;
                d.olsh = LSH_FOUR;
                d.def_spi = DUM_SIX;
            end
            default: begin
                // Unique ID, parameter table, info row act as fast read
                d.ok = (op == P_OP_UNIQUE_ID_READ) ||
                       (op == P_OP_PARAM_TABLE_READ) ||
                       (op == P_OP_INFO_ROW_READ);
            end
        endcase
        return d;
    endfunction

    // -------------------------------------------------------------------
    // State update
    // -------------------------------------------------------------------
    rdx_regs_s r_q;
    rdx_regs_s r_d;
    rdx_dec_s dec;
    logic sck_rise;
    logic sck_fall;
    logic in_ev;
    logic out_ev;
    logic [7:0] op;
    logic [7:0] word;
    logic [3:0] cfg_dummy;
    logic [3:0] in_bits;
    logic [7:0] wop;

    always_comb begin
        r_d = r_q;
        sck_rise = s_sck & ~r_q.sck_d;
        sck_fall = ~s_sck & r_q.sck_d;
        // DTR falls sample only after a rise, skipping the command's last fall
        in_ev = sck_rise | (r_q.dtr & sck_fall & r_q.cnt[0]);
        out_ev = sck_fall | (r_q.dtr & sck_rise);
        op = i_qpi_mode ? {r_q.cmd[3:0], s_io} : {r_q.cmd[6:0], s_io[0]};
        wop = i_qpi_mode ? {r_q.shift[3:0], s_io} : {r_q.shift[6:0], s_io[0]};
        dec = decode(op);
        word = (r_q.cnt == '0) ? i_rd_byte : r_q.shift;
        cfg_dummy = r_q.rp_v[RD_DUMMY_LSB +: 4];
        in_bits = '0;
        r_d.sck_d = s_sck;
        r_d.ext = {r_q.ep_v, EXT_RSVD_VAL, i_erase_err, i_prog_err,
                   i_protection_fail_flag,
                   i_write_in_progress};
        if (r_q.load_pend) begin
            r_d.rp_v = r_q.rp_nv;
            r_d.ep_v = r_q.ep_nv;
            r_d.load_pend = 1'b0;
        end
        if (s_cs_b) begin
            r_d.st = ST_CMD;
            r_d.cnt = i_qpi_mode ? (BYTE_BITS >> LSH_FOUR) : BYTE_BITS;
            r_d.dtr = 1'b0;
            r_d.io_oe = '0;
            r_d.cmd = '0;
        end else begin
            case (r_q.st)
                ST_CMD: begin
                    if (sck_rise) begin
                        r_d.cmd = op;
                        r_d.cnt = r_q.cnt - 6'h01;
                        if (r_q.cnt == 6'h01) begin
                            if (op == OP_SET_EXT_PARAMS_NONVOLATILE ||
                                op == OP_SET_EXT_PARAMS_VOLATILE ||
                                op == OP_SET_RD_PARAMS_NV ||
                                op == OP_SET_RD_PARAMS_V_A ||
                                op == OP_SET_RD_PARAMS_V_B) begin
                                r_d.st = ST_WDATA;
                                r_d.cnt = i_qpi_mode ?
                                    (BYTE_BITS >> LSH_FOUR) : BYTE_BITS;
                            end else if (dec.ok &&
                                    !(dec.spi_only && i_qpi_mode)) begin
                                r_d.st = ST_ADDR;
                                r_d.alsh = i_qpi_mode ? LSH_FOUR : dec.alsh;
                                r_d.olsh = i_qpi_mode ? LSH_FOUR : dec.olsh;
                                r_d.dtr = dec.dtr;
                                r_d.cnt = (dec.a4 ? ADDR_BITS4 : ADDR_BITS3)
                                    >> (i_qpi_mode ? LSH_FOUR : dec.alsh);
                                if (cfg_dummy == DUMMY_USE_DEFAULT) begin
                                    r_d.dummy = i_qpi_mode ? dec.def_qpi
                                        : dec.def_spi;
                                end else begin
                                    r_d.dummy = cfg_dummy;
                                end
                                r_d.addr = '0;
                            end else begin
                                r_d.st = ST_IGNORE;
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    if (in_ev) begin
                        case (r_q.alsh)
                            LSH_ONE: in_bits = {3'h0, s_io[0]};
                            LSH_TWO: in_bits = {2'h0, s_io[1:0]};
                            default: in_bits = s_io;
                        endcase
                        r_d.addr = (r_q.addr << (6'h01 << r_q.alsh)) |
                                   {28'h0, in_bits};
                        r_d.cnt = r_q.cnt - 6'h01;
                        if (r_q.cnt == 6'h01) begin
                            r_d.st = ST_DUMMY;
                            r_d.cnt = {2'h0, r_q.dummy};
                        end
                    end
                end
                ST_DUMMY: begin
                    if (sck_rise) begin
                        r_d.cnt = r_q.cnt - 6'h01;
                        if (r_q.cnt == 6'h01) begin
                            r_d.st = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (out_ev) begin
                        case (r_q.olsh)
                            LSH_ONE: begin
                                r_d.io_out = {2'h0, word[7], 1'b0};
                                r_d.io_oe = 4'h2;
                            end
                            LSH_TWO: begin
                                r_d.io_out = {2'h0, word[7:6]};
                                r_d.io_oe = 4'h3;
                            end
                            default: begin
                                r_d.io_out = word[7:4];
                                r_d.io_oe = 4'hF;
                            end
                        endcase
                        r_d.shift = word << (4'h1 << r_q.olsh);
                        if (r_q.cnt == '0) begin
                            r_d.cnt = (BYTE_BITS >> r_q.olsh) - 6'h01;
                            r_d.addr = r_q.addr + 32'h1;
                        end else begin
                            r_d.cnt = r_q.cnt - 6'h01;
                        end
                    end
                end
                ST_WDATA: begin
                    if (sck_rise) begin
                        r_d.shift = wop;
                        r_d.cnt = r_q.cnt - 6'h01;
                        if (r_q.cnt == 6'h01) begin
                            r_d.st = ST_IGNORE;
                            case (r_q.cmd)
                                OP_SET_EXT_PARAMS_NONVOLATILE:
                                    r_d.ep_nv = wop[7:5];
                                OP_SET_EXT_PARAMS_VOLATILE:
                                    r_d.ep_v = wop[7:5];
                                OP_SET_RD_PARAMS_NV: r_d.rp_nv = wop;
                                default: r_d.rp_v = wop;
                            endcase
                        end
                    end
                end
                default: begin
                    r_d.io_oe = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            r_q <= '{st: ST_CMD, sck_d: 1'b0, cnt: BYTE_BITS,
                     shift: 8'h00, cmd: 8'h00, addr: 32'h0,
                     alsh: LSH_ONE, olsh: LSH_ONE, dtr: 1'b0,
                     dummy: DUMMY_USE_DEFAULT, rp_nv: RD_PARAMS_RST,
                     rp_v: RD_PARAMS_RST, ep_nv: DRIVE_STRENGTH_RST,
                     ep_v: DRIVE_STRENGTH_RST, load_pend: 1'b1,
                     io_out: 4'h0, io_oe: 4'h0,
                     ext: {DRIVE_STRENGTH_RST, EXT_RSVD_VAL,
                           4'h0}};
        end else begin
            r_q <= r_d;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign o_io_out = r_q.io_out;
    assign o_io_oe = r_q.io_oe;
    assign o_rd_addr = r_q.addr;
    assign o_ext_params = r_q.ext;
    assign o_rd_params = r_q.rp_v;
    assign o_dummy_cnt = r_q.dummy;

endmodule
`default_nettype wire

//--- logic/rdx_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module rdx_sync #(
    parameter int W = 6
) (
    input wire logic i_sys_clk,   // System clock
    input wire logic i_rst_b,     // Sync reset, active low
    input wire logic [W-1:0] i_d, // Asynchronous inputs
    output logic [W-1:0] o_q      // Synchronised outputs
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule
`default_nettype wire
